// ==== design/dpll_pins_pkg.sv ====
package dpll_pins_pkg;
	// clock and timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam longint RESET_HOLD_NS = 3_000_000;
	localparam int RESET_HOLD_CYC = int'((RESET_HOLD_NS * 64'd1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS);
	localparam int MASTER_CLK_HZ = 20_000_000;
	// abrupt-change flag hold, counted in master clock periods
	localparam logic [7:0] ABRUPT_HOLD_TICKS = 8'h14;
	localparam int N_REF = 3;
	localparam int FREQ_W = 16;
	// out-of-range limit per application profile, same unit as the offset input
	localparam logic [15:0] OOR_LIMIT_P0 = 16'h0040;
	localparam logic [15:0] OOR_LIMIT_P1 = 16'h0050;
	localparam logic [15:0] OOR_LIMIT_P2 = 16'h0090;
	localparam logic [15:0] OOR_LIMIT_P3 = 16'h0090;
	// bit positions of the synchronised pin vector
	localparam int PIN_MODE_LSB = 0;
	localparam int PIN_MODE_MSB = 1;
	localparam int PIN_APP_LO = 2;
	localparam int PIN_HMS = 4;
	localparam int PIN_MCLK = 5;
	localparam int PIN_W = 6;
	// register map
	localparam int ADDR_W = 4;
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_EVENT = 4'h4;
	localparam logic [3:0] REG_MASK = 4'h8;
	// event bits, shared by the event and mask registers
	localparam int EV_LOCK_LOST = 0;
	localparam int EV_HOLDOVER = 1;
	localparam int EV_FAIL_LO = 2;
	localparam int EV_MEASURE = 5;
	localparam int EV_W = 6;
	localparam logic [5:0] MASK_RESET = 6'h00;
	typedef enum logic [1:0] {MODE_NORMAL, MODE_HOLDOVER, MODE_FREERUN, MODE_AUTO} op_mode_e;
	typedef enum logic [1:0] {ST_RESET, ST_FREERUN, ST_NORMAL, ST_HOLDOVER} loop_state_e;
endpackage

// ==== design/dpll_mode_status_pins.sv ====
// Function
// - lock high while locked to selected reference
// - holdover high while loop in holdover
// - failure flag on out-of-range frequency per profile
// - failure flag on abrupt phase/frequency change
// - three flags, each for its own reference
// - hitless input acts only on same-reference return
// - hitless low keeps stored corrector delay
// - hitless high measures new corrector delay
// - two mode pins decoded as one code
// - 3 ms internal reset, clock outputs disabled
// - master clock is monitoring timebase
// - application pins choose profile and limits
`timescale 1ns/100ps
module dpll_mode_status_pins
	import dpll_pins_pkg::*;
#(
	parameter int unsigned RESET_HOLD_CYCLES = dpll_pins_pkg::RESET_HOLD_CYC
)(
	input wire logic clk_i, // 125 MHz core clock
	input wire logic rstn_i, // async reset, active low
	input wire logic master_clock_in_i, // 20 MHz master clock pin
	input wire logic op_mode_select_lsb_i, // mode code bit 0 pin
	input wire logic op_mode_select_msb_i, // mode code bit 1 pin
	input wire logic [1:0] application_profile_select_i, // profile pins
	input wire logic hitless_mode_switch_sel_i, // hitless mode switching pin
	input wire logic pll_freq_locked_i, // loop core reports frequency lock
	input wire logic [1:0] ref_select_i, // manual reference choice
	input wire logic [dpll_pins_pkg::N_REF*dpll_pins_pkg::FREQ_W-1:0] ref_freq_offset_i, // signed
	input wire logic [dpll_pins_pkg::N_REF-1:0] ref_abrupt_i, // abrupt change pulses
	input wire logic [dpll_pins_pkg::ADDR_W-1:0] addr_i, // register byte address
	input wire logic [31:0] wdata_i, // write data
	input wire logic wr_i, // write strobe
	input wire logic rd_i, // read strobe
	output logic [31:0] rdata_o, // read data, cycle after rd_i
	output logic lock_o, // frequency lock status
	output logic holdover_o, // holdover status
	output logic ref_a_failure_flag_o, // reference 0 failed
	output logic ref_b_failure_flag_o, // reference 1 failed
	output logic ref_c_failure_flag_o, // reference 2 failed
	output logic clk_out_oe_o, // enable for clock and frame pulse outputs
	output logic [1:0] active_ref_o, // reference in use
	output logic corrector_measure_o, // pulse: measure new corrector delay
	output logic corrector_keep_o, // pulse: keep stored corrector delay
	output logic irq_o // level interrupt
);
	import dpll_pins_pkg::*;

	localparam int HW = $clog2(RESET_HOLD_CYCLES + 1);

	if (RESET_HOLD_CYCLES < 1 || RESET_HOLD_CYCLES > 32'h00FF_FFFF)
	begin : g_bad_hold
		$error("reset hold count out of range");
	end

	typedef struct packed {
		logic [PIN_W-1:0] pin_s1;
		logic [PIN_W-1:0] pin_s2;
		logic [PIN_W-1:0] pin_s3;
		logic [PIN_W-1:0] pin_f;
		logic mclk_prev;
		logic [HW-1:0] hold_cnt;
		loop_state_e st;
		logic [1:0] ref_cur;
		logic [N_REF-1:0] fail;
		logic [N_REF-1:0][7:0] abrupt_cnt;
		logic lock;
		logic holdover;
		logic oe;
		logic measure;
		logic keep;
		logic [EV_W-1:0] ev;
		logic [EV_W-1:0] mask;
		logic [31:0] rdata;
		logic irq;
	} state_s;

	state_s q, d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [N_REF-1:0] oor;
	logic [15:0] limit;

	// reset release through two flip-flops, assertion stays asynchronous
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// profile limit from the filtered application pins
	always_comb
	begin
		unique case (q.pin_f[PIN_APP_LO +: 2])
			2'b00: limit = OOR_LIMIT_P0;
			2'b01: limit = OOR_LIMIT_P1;
			2'b10: limit = OOR_LIMIT_P2;
			2'b11: limit = OOR_LIMIT_P3;
		endcase
	end

	// magnitude compare per reference; each uses only its own offset
	for (genvar i = 0; i < N_REF; i++)
	begin : g_oor
		logic signed [FREQ_W-1:0] off;
		logic [FREQ_W-1:0] mag;
		assign off = ref_freq_offset_i[i*FREQ_W +: FREQ_W];
		assign mag = off[FREQ_W-1] ? FREQ_W'(-off) : off;
		assign oor[i] = mag > limit;
	end

	// next-state logic for the whole block
	always_comb
	begin
		logic mtick;
		logic hitless_mode_switch_sel;
		op_mode_e mode;
		logic [1:0] pick;
		logic any_good;
		logic [1:0] want;
		logic [EV_W-1:0] clr;
		logic [EV_W-1:0] set;
		mtick = 1'b0;
		hitless_mode_switch_sel = 1'b0;
		mode = MODE_NORMAL;
		pick = 2'd0;
		any_good = 1'b0;
		want = 2'd0;
		clr = '0;
		set = '0;
		d = q;
		d.measure = 1'b0;
		d.keep = 1'b0;
		d.rdata = 32'h0000_0000;

		// pins: three stages, a change counts once stages two and three agree
		d.pin_s1 = {master_clock_in_i, hitless_mode_switch_sel_i,
			application_profile_select_i, op_mode_select_msb_i, op_mode_select_lsb_i};
		d.pin_s2 = q.pin_s1;
		d.pin_s3 = q.pin_s2;
		d.pin_f = (q.pin_s2 & q.pin_s3) | (q.pin_f & (q.pin_s2 | q.pin_s3));

		// master clock edges pace the monitor timers
		d.mclk_prev = q.pin_f[PIN_MCLK];
		mtick = q.pin_f[PIN_MCLK] & ~q.mclk_prev;
		mode = op_mode_e'({q.pin_f[PIN_MODE_MSB], q.pin_f[PIN_MODE_LSB]});
		hitless_mode_switch_sel = q.pin_f[PIN_HMS];

		// failure flags: out of range, or inside the abrupt-change hold
		for (int i = 0; i < N_REF; i++)
		begin
			if (ref_abrupt_i[i])
				d.abrupt_cnt[i] = ABRUPT_HOLD_TICKS;
			else if (mtick && q.abrupt_cnt[i] != 8'h00)
				d.abrupt_cnt[i] = q.abrupt_cnt[i] - 8'h01;
			d.fail[i] = oor[i] | ref_abrupt_i[i] | (d.abrupt_cnt[i] != 8'h00);
		end

		// lowest-numbered healthy reference for automatic mode
		for (int i = N_REF - 1; i >= 0; i--)
		begin
			if (!q.fail[i])
			begin
				pick = 2'(i);
				any_good = 1'b1;
			end
		end
		want = (mode == MODE_AUTO) ? pick : ((ref_select_i == 2'd3) ? 2'd2 : ref_select_i);

		unique case (q.st)
			ST_RESET:
			begin
				// outputs stay disabled until the hold has run out
				d.hold_cnt = q.hold_cnt + HW'(1);
				if (q.hold_cnt == HW'(RESET_HOLD_CYCLES - 1))
					d.st = ST_FREERUN;
			end
			ST_FREERUN, ST_HOLDOVER:
			begin
				if (mode == MODE_FREERUN)
					d.st = ST_FREERUN;
				else if (mode == MODE_HOLDOVER || (mode == MODE_AUTO && !any_good))
					d.st = (q.st == ST_HOLDOVER) ? ST_HOLDOVER : ST_FREERUN;
				else
				begin
					// return to normal: hitless pin matters only on the same reference
					d.st = ST_NORMAL;
					d.ref_cur = want;
					if (want == q.ref_cur)
					begin
						d.measure = hitless_mode_switch_sel;
						d.keep = ~hitless_mode_switch_sel;
					end
					else
						d.measure = 1'b1;
				end
			end
			ST_NORMAL:
			begin
				if (mode == MODE_FREERUN)
					d.st = ST_FREERUN;
				else if (mode == MODE_HOLDOVER || (mode == MODE_AUTO && !any_good))
					d.st = ST_HOLDOVER;
				else if (want != q.ref_cur)
				begin
					// reference switch is always hitless
					d.ref_cur = want;
					d.measure = 1'b1;
				end
			end
		endcase

		// status pins, registered so they never glitch
		d.oe = (d.st != ST_RESET);
		d.lock = (d.st == ST_NORMAL) && pll_freq_locked_i;
		d.holdover = (d.st == ST_HOLDOVER);
		if (d.st == ST_RESET)
			d.fail = '0;

		// sticky events, a set in the clearing cycle wins
		set[EV_LOCK_LOST] = q.lock & ~d.lock;
		set[EV_HOLDOVER] = ~q.holdover & d.holdover;
		set[EV_FAIL_LO +: N_REF] = d.fail & ~q.fail;
		set[EV_MEASURE] = d.measure;
		if (wr_i && addr_i == REG_EVENT)
			clr = wdata_i[EV_W-1:0];
		if (wr_i && addr_i == REG_MASK)
			d.mask = wdata_i[EV_W-1:0];
		d.ev = (q.ev & ~clr) | set;
		d.irq = |(d.ev & d.mask);

		// reads answer next cycle; unmapped addresses read zero
		if (rd_i)
		begin
			unique case (addr_i)
				REG_STATUS: d.rdata = {22'h00_0000, q.pin_f[PIN_MODE_MSB], q.pin_f[PIN_MODE_LSB],
					q.ref_cur, q.fail, q.oe, q.holdover, q.lock};
				REG_EVENT: d.rdata = {26'h000_0000, q.ev};
				REG_MASK: d.rdata = {26'h000_0000, q.mask};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
	end

	// single state register; reset state is all zeros with the loop in reset
	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			q <= '0;
		else
			q <= d;
	end

	assign rdata_o = q.rdata;
	assign lock_o = q.lock;
	assign holdover_o = q.holdover;
	assign ref_a_failure_flag_o = q.fail[0];
	assign ref_b_failure_flag_o = q.fail[1];
	assign ref_c_failure_flag_o = q.fail[2];
	assign clk_out_oe_o = q.oe;
	assign active_ref_o = q.ref_cur;
	assign corrector_measure_o = q.measure;
	assign corrector_keep_o = q.keep;
	assign irq_o = q.irq;

	// helper terms read only by the checks below
	logic lock_cause;
	logic ret_same;
	logic free_req;
	assign lock_cause = (d.st == ST_NORMAL) && pll_freq_locked_i;
	assign ret_same = (q.st == ST_HOLDOVER || q.st == ST_FREERUN) && d.st == ST_NORMAL
		&& d.ref_cur == q.ref_cur;
	assign free_req = q.st != ST_RESET && q.pin_f[PIN_MODE_MSB] && !q.pin_f[PIN_MODE_LSB];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	sequence same_ref_return;
		ret_same;
	endsequence

	lock_follows_a: assert property (lock_cause |=> lock_o)
		else $error("lock status missed its cause");
	holdover_state_a: assert property (holdover_o == (q.st == ST_HOLDOVER))
		else $error("holdover status disagrees with loop state");
	range_fail_a: assert property (oor[0] && q.st != ST_RESET |=> ref_a_failure_flag_o)
		else $error("out-of-range reference not flagged");
	abrupt_hold_a: assert property (ref_abrupt_i[1] && q.st != ST_RESET
		|=> ref_b_failure_flag_o [*8])
		else $error("abrupt change flag not held");
	own_ref_a: assert property (q.abrupt_cnt[2] == 8'h00 && !oor[2] && !ref_abrupt_i[2]
		|=> !ref_c_failure_flag_o)
		else $error("flag raised without its own reference failing");
	keep_delay_a: assert property (same_ref_return ##0 !q.pin_f[PIN_HMS]
		|=> corrector_keep_o && !corrector_measure_o)
		else $error("stored delay not kept on return");
	measure_delay_a: assert property (same_ref_return ##0 q.pin_f[PIN_HMS]
		|=> corrector_measure_o && !corrector_keep_o)
		else $error("new delay not measured on return");
	mode_decode_a: assert property (free_req |=> q.st == ST_FREERUN && !lock_o && !holdover_o)
		else $error("freerun code not decoded");
	reset_quiet_a: assert property (q.st == ST_RESET |-> !clk_out_oe_o && !lock_o
		&& !holdover_o && !ref_a_failure_flag_o && !ref_b_failure_flag_o
		&& !ref_c_failure_flag_o)
		else $error("outputs active during internal reset");
	reset_hold_a: assert property (q.st == ST_RESET && q.hold_cnt < HW'(RESET_HOLD_CYCLES - 1)
		|=> q.st == ST_RESET)
		else $error("internal reset ended early");
endmodule

// ==== bench/board_ctrl_model.sv ====
`timescale 1ns/100ps
// board side: master clock source and the static select pins
module board_ctrl_model (
	input wire logic clk_i, // core clock, pins move after its edge
	output logic master_clock_o, // 20 MHz master clock
	output logic [1:0] mode_o, // {msb,lsb} mode code
	output logic [1:0] app_o, // application profile
	output logic hms_o // hitless mode switching
);
	// free-running oscillator, 25 ns half period, unrelated to the core clock
	initial master_clock_o = 1'b0;
	always #25 master_clock_o = ~master_clock_o;
	initial
	begin
		mode_o = 2'h0;
		app_o = 2'h0;
		hms_o = 1'b0;
	end
	// pins change only just after a core edge, so no half-cycle glitch reaches the filter
	task automatic set_pins(input logic [1:0] m, input logic [1:0] a, input logic h);
		@(posedge clk_i);
		mode_o <= m;
		app_o <= a;
		hms_o <= h;
	endtask
endmodule

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
	import dpll_pins_pkg::*;
	localparam int HOLD = 50;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic pll_freq_locked_i = 1'b0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [1:0] ref_select_i = 2'h0;
	logic [47:0] ref_freq_offset_i = 48'h0;
	logic [2:0] ref_abrupt_i = 3'h0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o;
	logic [31:0] rv;
	logic mclk, hitless_mode_switch_sel, lock_o, holdover_o, fa, fb, fc, oe, meas, keep, irq_o;
	logic [1:0] mode;
	logic [1:0] act;
	logic [1:0] app;
	int errors = 0;
	int samples_checked = 0;
	always #4 clk_i = ~clk_i;
	board_ctrl_model board_ctrl_model_i (.clk_i(clk_i), .master_clock_o(mclk), .mode_o(mode),
		.app_o(app), .hms_o(hitless_mode_switch_sel));
	dpll_mode_status_pins #(.RESET_HOLD_CYCLES(HOLD)) dpll_mode_status_pins_i (
		.clk_i(clk_i), .rstn_i(rstn_i), .master_clock_in_i(mclk),
		.op_mode_select_lsb_i(mode[0]), .op_mode_select_msb_i(mode[1]),
		.application_profile_select_i(app), .hitless_mode_switch_sel_i(hitless_mode_switch_sel),
		.pll_freq_locked_i(pll_freq_locked_i), .ref_select_i(ref_select_i),
		.ref_freq_offset_i(ref_freq_offset_i), .ref_abrupt_i(ref_abrupt_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .lock_o(lock_o),
		.holdover_o(holdover_o), .ref_a_failure_flag_o(fa), .ref_b_failure_flag_o(fb),
		.ref_c_failure_flag_o(fc), .clk_out_oe_o(oe), .active_ref_o(act),
		.corrector_measure_o(meas), .corrector_keep_o(keep), .irq_o(irq_o));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task automatic end_sim;
		if (errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// outputs stay quiet in reset and through the internal reset span, then the enable rises
	task automatic t_reset(input int low);
		int n;
		n = 0;
		@(posedge clk_i);
		rstn_i <= 1'b0;
		repeat (low - 1) @(posedge clk_i);
		#1;
		chk("reset_quiet", {oe, fc, fb, fa, lock_o, holdover_o, irq_o, meas, keep, act},
			0);
		@(posedge clk_i);
		rstn_i <= 1'b1;
		cyc(10);
		chk("oe_in_reset", oe, 0);
		chk("flags_in_reset", {fc, fb, fa, lock_o, holdover_o}, 0);
		while (oe !== 1'b1 && n < 300)
		begin
			cyc(1);
			n++;
		end
		// enable rises two release edges plus the hold count after release; ten already passed
		chk("oe_delay", n, HOLD - 8);
	endtask
	task automatic t_lock;
		pll_freq_locked_i <= 1'b1;
		cyc(10);
		chk("lock", {lock_o, holdover_o}, 2'h2);
		pll_freq_locked_i <= 1'b0;
		cyc(3);
		chk("lock_lost", lock_o, 0);
		pll_freq_locked_i <= 1'b1;
		cyc(3);
	endtask
	// holdover entry, its event, masking and clearing of the interrupt
	task automatic t_holdover;
		wr(REG_EVENT, 32'h0000_003F);
		wr(REG_MASK, 32'h0000_0002);
		board_ctrl_model_i.set_pins(2'h1, 2'h0, 1'b0);
		cyc(8);
		chk("holdover", {lock_o, holdover_o}, 2'h1);
		chk("irq_set", irq_o, 1);
		rd(REG_STATUS, rv);
		chk("status", rv[9:0], 10'h106);
		rd(REG_EVENT, rv);
		chk("event", rv[1:0], 2'h3);
		cyc(1);
		chk("rdata_idle", rdata_o, 0);
		wr(REG_MASK, 32'h0000_0000);
		cyc(2);
		chk("irq_masked", irq_o, 0);
		wr(REG_MASK, 32'h0000_0002);
		wr(REG_EVENT, 32'h0000_0002);
		cyc(2);
		chk("irq_cleared", irq_o, 0);
		rd(4'hC, rv);
		chk("unmapped", rv, 0);
	endtask
	// return to normal on the same reference; the hitless pin picks keep or measure
	task automatic t_return(input logic h);
		board_ctrl_model_i.set_pins(2'h0, 2'h0, h);
		repeat (20)
		begin
			@(posedge clk_i);
			#1;
			if (meas | keep)
				break;
		end
		chk("corr_keep", keep, !h);
		chk("corr_measure", meas, h);
		board_ctrl_model_i.set_pins(2'h1, 2'h0, h);
		cyc(8);
	endtask
	// each profile limit at its edge: equal passes, one above fails its own flag only
	task automatic t_fail;
		logic [15:0] lim;
		for (int p = 0; p < 4; p++)
		begin
			lim = p == 0 ? OOR_LIMIT_P0 : p == 1 ? OOR_LIMIT_P1 : p == 2 ? OOR_LIMIT_P2 : OOR_LIMIT_P3;
			board_ctrl_model_i.set_pins(2'h0, p[1:0], 1'b0);
			for (int r = 0; r < 3; r++)
			begin
				// one assignment per step; the other two offsets drop to zero
				ref_freq_offset_i <= 48'(lim) << (r * 16);
				cyc(8);
				chk("fail_at_limit", {fc, fb, fa}, 0);
				ref_freq_offset_i[r*16 +: 16] <= lim + 16'h0001;
				cyc(3);
				chk("fail_over", {fc, fb, fa}, 3'h1 << r);
			end
			ref_freq_offset_i <= 48'h0;
		end
	endtask
	task automatic t_abrupt;
		ref_abrupt_i <= 3'h2;
		@(posedge clk_i);
		ref_abrupt_i <= 3'h0;
		cyc(3);
		chk("abrupt_set", {fc, fb, fa}, 3'h2);
		cyc(100);
		chk("abrupt_held", {fc, fb, fa}, 3'h2);
		cyc(150);
		chk("abrupt_gone", {fc, fb, fa}, 0);
	endtask
	// manual switch, freerun, return on another reference, then the automatic choice
	task automatic t_ref;
		wr(REG_EVENT, 32'h0000_003F);
		cyc(1);
		ref_select_i <= 2'h1;
		cyc(1);
		chk("switch_measure", {act, meas, keep}, 4'h6);
		rd(REG_EVENT, rv);
		chk("measure_event", rv[5:0], 6'h20);
		board_ctrl_model_i.set_pins(2'h2, 2'h3, 1'b0);
		cyc(8);
		rd(REG_STATUS, rv);
		chk("freerun", {lock_o, holdover_o, rv[9:8], rv[2:0]}, 7'h14);
		// a change of reference while in freerun is only taken on the way back
		ref_select_i <= 2'h2;
		board_ctrl_model_i.set_pins(2'h0, 2'h3, 1'b0);
		repeat (20)
		begin
			@(posedge clk_i);
			#1;
			if (meas | keep)
				break;
		end
		chk("other_ref_return", {act, meas, keep}, 4'ha);
		board_ctrl_model_i.set_pins(2'h3, 2'h3, 1'b0);
		cyc(8);
		chk("auto_pick", act, 2'h0);
		ref_freq_offset_i <= 48'h0000_0000_0100;
		cyc(3);
		chk("auto_skip_failed", {act, fc, fb, fa}, 5'h09);
		ref_freq_offset_i <= 48'h0100_0100_0100;
		cyc(3);
		chk("auto_none_good", {lock_o, holdover_o}, 2'h1);
		ref_freq_offset_i <= 48'h0;
		cyc(3);
	endtask
	initial
	begin
		t_reset(3);
		t_lock;
		t_holdover;
		t_return(1'b0);
		t_return(1'b1);
		t_fail;
		t_abrupt;
		t_ref;
		// second reset mid-run, 38 cycles of 8 ns cover the board's minimum low time
		t_reset(38);
		end_sim;
	end
	// watchdog well beyond the under one thousand cycles the sequence needs
	initial
	begin
		#200_000;
		errors++;
		end_sim;
	end
endmodule
